//--- shared/ubfc_pkg.sv
// Constants and types shared by the baud and frame configuration block
package ubfc_pkg;

  // Bus and datapath widths
  localparam int DATA_W    = 8;
  localparam int ADDR_W    = 3;
  localparam int DIV_W     = 12;
  localparam int CHAR_W    = 9;
  localparam int PH_W      = 4;
  localparam int CNT_W     = 4;
  localparam int FIFO_DEPTH = 16;

  // Register offsets
  localparam logic [ADDR_W-1:0] ADDR_DIV_LOW = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_SHARED  = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_B  = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_STATUS  = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_TX_DATA = 3'h4;
  localparam logic [ADDR_W-1:0] ADDR_RX_DATA = 3'h5;

  // Frame control fields (shared address, select bit set)
  localparam int FC_SEL    = 7;
  localparam int FC_SYNC   = 6;
  localparam int FC_CSZ_HI = 2;
  localparam int FC_CSZ_LO = 1;
  localparam int FC_POL    = 0;

  // Serial control b fields
  localparam int CB_CSZ_TOP = 0;
  localparam int CB_DSPEED  = 1;
  localparam int CB_CLKDIR  = 2;
  localparam int CB_TX_EN   = 3;
  localparam int CB_RX_EN   = 4;
  localparam int CB_TX_BIT8 = 5;

  // Status fields
  localparam int ST_TX_READY = 0;
  localparam int ST_RX_FULL  = 1;
  localparam int ST_TX_BUSY  = 2;
  localparam int ST_RX_BIT8  = 3;
  localparam int ST_OVERRUN  = 4;

  // Divisor high byte layout
  localparam int DIV_HI_LSB = 8;
  localparam int DIV_HI_W   = 4;

  // Reset values
  localparam logic [DIV_W-1:0]  RST_DIV = 12'h000;
  localparam logic [DATA_W-1:0] RST_FC  = 8'h06;
  localparam logic [DATA_W-1:0] RST_CB  = 8'h00;

  // Last phase index of the async recovery state machines (16 and 8 states)
  localparam logic [PH_W-1:0] LAST_PH_NORM   = 4'hf;
  localparam logic [PH_W-1:0] LAST_PH_DSPEED = 4'h7;

  // Character size codes and bit counts
  localparam logic [2:0] CSZ_5 = 3'h0;
  localparam logic [2:0] CSZ_6 = 3'h1;
  localparam logic [2:0] CSZ_7 = 3'h2;
  localparam logic [2:0] CSZ_8 = 3'h3;
  localparam logic [2:0] CSZ_9 = 3'h7;
  localparam logic [CNT_W-1:0] BITS_5 = 4'h5;
  localparam logic [CNT_W-1:0] BITS_6 = 4'h6;
  localparam logic [CNT_W-1:0] BITS_7 = 4'h7;
  localparam logic [CNT_W-1:0] BITS_8 = 4'h8;
  localparam logic [CNT_W-1:0] BITS_9 = 4'h9;

  // Frame sequencer states, Gray along idle-start-data-stop
  typedef enum logic [1:0] {
    FR_IDLE  = 2'b00,
    FR_START = 2'b01,
    FR_DATA  = 2'b11,
    FR_STOP  = 2'b10
  } ubfc_fsm_t;

endpackage

//--- verilog/ubfc_top.sv
// Baud generator, frame configuration and serial engine with transmit FIFO
`timescale 1ns/100ps
`default_nettype none

module ubfc_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // Filling side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Draining side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             count;
  } ubfc_fifo_state_t;

  ubfc_fifo_state_t s_r;
  ubfc_fifo_state_t s_nxt;
  logic             push;
  logic             pop;

  assign in_ready  = (s_r.count != DEPTH[AW:0]);
  assign out_valid = (s_r.count != '0);
  assign out_data  = s_r.mem[s_r.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    s_nxt = s_r;
    if (push)
    begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp = s_r.wp + 1'b1;
    end
    if (pop)
      s_nxt.rp = s_r.rp + 1'b1;
    if (push && !pop)
      s_nxt.count = s_r.count + 1'b1;
    else if (pop && !push)
      s_nxt.count = s_r.count - 1'b1;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end
endmodule

// What this block does
// - Baud down-counter reloads divisor at zero and on low divisor byte write.
// - Each zero count emits one baud tick, rate clock over divisor plus one.
// - Transmit bit clock is baud tick divided by 16 or 8 in async mode and by 2 as sync master.
// - Async receiver steps 8 or 16 states from baud tick, chosen by double-speed bit.
// - Internal baud clock serves async mode and sync master mode.
// - Sync master mode drives the generated serial clock on the clock pin.
// - Size code gives 5,6,7,8 or 9 data bits; codes 100 to 110 reserved.
// - Polarity 0 launches on rising and samples on falling edge; 1 swaps.
// - Divisor high byte and frame control share one address, top bit selects.
// - Reading divisor high byte returns zero in the select bit.
module ubfc_top
  import ubfc_pkg::*;
#(
  parameter int TX_FIFO_DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  // Serial data pins
  input  wire logic              rxd,
  output logic                   txd,
  // Serial clock pin
  input  wire logic              xck_in,
  output logic                   xck_out,
  output logic                   xck_oe,
  // Flow and timing
  output logic                   tx_fifo_ready,
  output logic                   baud_tick
);

  typedef struct packed {
    logic [DIV_W-1:0]  cnt;
    logic [DIV_W-1:0]  div;
    logic [DATA_W-1:0] fc;
    logic [DATA_W-1:0] cb;
    logic              rxd_s1;
    logic              rxd_s2;
    logic              xck_s1;
    logic              xck_s2;
    logic              xck_s3;
    logic              xck_r;
    logic [PH_W-1:0]   tx_ph;
    ubfc_fsm_t         tx_st;
    logic [CHAR_W-1:0] tx_sh;
    logic [CNT_W-1:0]  tx_n;
    logic              txd;
    logic [PH_W-1:0]   rx_ph;
    ubfc_fsm_t         rx_st;
    logic [CHAR_W-1:0] rx_sh;
    logic [CNT_W-1:0]  rx_n;
    logic [CHAR_W-1:0] rx_data;
    logic              rx_full;
    logic              ovr;
    logic [DATA_W-1:0] rdata;
  } ubfc_state_t;

  localparam ubfc_state_t ST_RESET = '{
    div:     RST_DIV,
    cnt:     RST_DIV,
    fc:      RST_FC,
    cb:      RST_CB,
    txd:     1'b1,
    // Line idles high, so the synchroniser starts there to avoid a false start
    rxd_s1:  1'b1,
    rxd_s2:  1'b1,
    tx_st:   FR_IDLE,
    rx_st:   FR_IDLE,
    default: '0
  };

  ubfc_state_t       s_r;
  ubfc_state_t       s_nxt;
  logic              fifo_valid;
  logic              fifo_pop;
  logic [CHAR_W-1:0] fifo_data;
  logic              fifo_push;

  // Frame length lookup; reserved codes fall back to eight bits
  function automatic logic [CNT_W-1:0] char_bits(input logic [2:0] code);
    logic [CNT_W-1:0] n;
    n = BITS_8;
    unique case (code)
      CSZ_5:   n = BITS_5;
      CSZ_6:   n = BITS_6;
      CSZ_7:   n = BITS_7;
      CSZ_8:   n = BITS_8;
      CSZ_9:   n = BITS_9;
      default: n = BITS_8;
    endcase
    return n;
  endfunction

  logic             tick;
  logic             sync_mode;
  logic             master;
  logic             int_rise;
  logic             int_fall;
  logic             ext_rise;
  logic             ext_fall;
  logic             clk_rise;
  logic             clk_fall;
  logic             launch;
  logic             sample;
  logic [PH_W-1:0]  last_ph;
  logic [PH_W-1:0]  mid_ph;
  logic             tx_step;
  logic             rx_sample;
  logic [CNT_W-1:0] nbits;

  always_comb
  begin
    tick      = (s_r.cnt == '0);
    sync_mode = s_r.fc[FC_SYNC];
    master    = s_r.cb[CB_CLKDIR];
    nbits     = char_bits({s_r.cb[CB_CSZ_TOP], s_r.fc[FC_CSZ_HI:FC_CSZ_LO]});
    int_rise  = tick && !s_r.xck_r;
    int_fall  = tick && s_r.xck_r;
    ext_rise  = s_r.xck_s2 && !s_r.xck_s3;
    ext_fall  = !s_r.xck_s2 && s_r.xck_s3;
    clk_rise  = master ? int_rise : ext_rise;
    clk_fall  = master ? int_fall : ext_fall;
    launch    = s_r.fc[FC_POL] ? clk_fall : clk_rise;
    sample    = s_r.fc[FC_POL] ? clk_rise : clk_fall;
    last_ph   = s_r.cb[CB_DSPEED] ? LAST_PH_DSPEED : LAST_PH_NORM;
    mid_ph    = last_ph >> 1;
    // divide by 16 or 8 async, by 2 as sync master; sync slave steps on the clock pin
    tx_step   = sync_mode ? launch : (tick && s_r.tx_ph == last_ph);
    rx_sample = sync_mode ? sample : (tick && s_r.rx_ph == mid_ph);
  end

  assign fifo_push     = reg_wr && (reg_addr == ADDR_TX_DATA);
  assign fifo_pop      = (s_r.tx_st == FR_IDLE) && tx_step && s_r.cb[CB_TX_EN];
  assign txd           = s_r.txd;
  assign baud_tick     = tick;
  assign reg_rdata     = s_r.rdata;
  // drive clock only as sync master
  assign xck_out       = s_r.xck_r;
  assign xck_oe        = sync_mode && master;

  // A full FIFO drops the write; software polls tx_fifo_ready or status first
  ubfc_fifo #(
    .W     (CHAR_W),
    .DEPTH (TX_FIFO_DEPTH)
  ) u_tx_fifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_valid  (fifo_push),
    .in_ready  (tx_fifo_ready),
    .in_data   ({s_r.cb[CB_TX_BIT8], reg_wdata}),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  always_comb
  begin
    s_nxt = s_r;
    // Pins pass two flops, the clock pin a third; only the second and third stage feed logic
    s_nxt.rxd_s1 = rxd;
    s_nxt.rxd_s2 = s_r.rxd_s1;
    s_nxt.xck_s1 = xck_in;
    s_nxt.xck_s2 = s_r.xck_s1;
    s_nxt.xck_s3 = s_r.xck_s2;

    if (tick)
      s_nxt.cnt = s_r.div;
    else
      s_nxt.cnt = s_r.cnt - 1'b1;
    if (tick)
      s_nxt.xck_r = !s_r.xck_r;
    if (tick)
      s_nxt.tx_ph = (s_r.tx_ph == last_ph) ? '0 : s_r.tx_ph + 1'b1;
    if (tick)
      s_nxt.rx_ph = (s_r.rx_ph == last_ph) ? '0 : s_r.rx_ph + 1'b1;

    // Register writes
    if (reg_wr)
    begin
      unique case (reg_addr)
        ADDR_DIV_LOW:
        begin
          s_nxt.div[DIV_HI_LSB-1:0] = reg_wdata;
          s_nxt.cnt = {s_r.div[DIV_W-1:DIV_HI_LSB], reg_wdata};
        end
        ADDR_SHARED:
        begin
          if (reg_wdata[FC_SEL])
            s_nxt.fc = reg_wdata;
          else
            s_nxt.div[DIV_W-1:DIV_HI_LSB] = reg_wdata[DIV_HI_W-1:0];
        end
        ADDR_CTRL_B:
          s_nxt.cb = reg_wdata;
        default:
          s_nxt.cb = s_r.cb;
      endcase
    end

    // Register reads; data stand only in the following cycle
    s_nxt.rdata = '0;
    if (reg_rd)
    begin
      unique case (reg_addr)
        ADDR_DIV_LOW:
          s_nxt.rdata = s_r.div[DIV_HI_LSB-1:0];
        ADDR_SHARED:
          s_nxt.rdata = {{(DATA_W-DIV_HI_W){1'b0}}, s_r.div[DIV_W-1:DIV_HI_LSB]};
        ADDR_CTRL_B:
          s_nxt.rdata = s_r.cb;
        ADDR_STATUS:
        begin
          s_nxt.rdata[ST_TX_READY] = tx_fifo_ready;
          s_nxt.rdata[ST_RX_FULL]  = s_r.rx_full;
          s_nxt.rdata[ST_TX_BUSY]  = (s_r.tx_st != FR_IDLE) || fifo_valid;
          s_nxt.rdata[ST_RX_BIT8]  = s_r.rx_data[CHAR_W-1];
          s_nxt.rdata[ST_OVERRUN]  = s_r.ovr;
        end
        ADDR_RX_DATA:
        begin
          s_nxt.rdata   = s_r.rx_data[DATA_W-1:0];
          s_nxt.rx_full = 1'b0;
          s_nxt.ovr     = 1'b0;
        end
        default:
          s_nxt.rdata = '0;
      endcase
    end

    // Transmit sequencer, LSB first, one stop bit
    if (tx_step)
    begin
      unique case (s_r.tx_st)
        FR_IDLE:
          if (fifo_pop && fifo_valid)
          begin
            s_nxt.tx_sh = fifo_data;
            s_nxt.txd   = 1'b0;
            s_nxt.tx_st = FR_START;
          end
        FR_START:
        begin
          s_nxt.txd   = s_r.tx_sh[0];
          s_nxt.tx_sh = s_r.tx_sh >> 1;
          s_nxt.tx_n  = '0;
          s_nxt.tx_st = FR_DATA;
        end
        FR_DATA:
          if (s_r.tx_n == nbits - 1'b1)
          begin
            s_nxt.txd   = 1'b1;
            s_nxt.tx_st = FR_STOP;
          end
          else
          begin
            s_nxt.txd   = s_r.tx_sh[0];
            s_nxt.tx_sh = s_r.tx_sh >> 1;
            s_nxt.tx_n  = s_r.tx_n + 1'b1;
          end
        FR_STOP:
          s_nxt.tx_st = FR_IDLE;
      endcase
    end

    // Receive sequencer; async start re-aligns the phase counter
    unique case (s_r.rx_st)
      FR_IDLE:
        if (s_r.cb[CB_RX_EN] && !s_r.rxd_s2)
        begin
          if (!sync_mode)
          begin
            s_nxt.rx_ph = '0;
            s_nxt.rx_st = FR_START;
          end
          else if (rx_sample)
          begin
            s_nxt.rx_n  = '0;
            s_nxt.rx_st = FR_DATA;
          end
        end
      FR_START:
        // Mid-bit check rejects a false start
        if (rx_sample)
        begin
          s_nxt.rx_n  = '0;
          s_nxt.rx_st = s_r.rxd_s2 ? FR_IDLE : FR_DATA;
        end
      FR_DATA:
        if (rx_sample)
        begin
          s_nxt.rx_sh = {s_r.rxd_s2, s_r.rx_sh[CHAR_W-1:1]};
          s_nxt.rx_n  = s_r.rx_n + 1'b1;
          if (s_r.rx_n == nbits - 1'b1)
            s_nxt.rx_st = FR_STOP;
        end
      FR_STOP:
        if (rx_sample)
        begin
          // New data wins over a read-clear in the same cycle
          s_nxt.rx_data = s_r.rx_sh >> (CNT_W'(CHAR_W) - nbits);
          s_nxt.rx_full = 1'b1;
          if (s_r.rx_full && !(reg_rd && reg_addr == ADDR_RX_DATA))
            s_nxt.ovr = 1'b1;
          s_nxt.rx_st = FR_IDLE;
        end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      s_r <= ST_RESET;
    else
      s_r <= s_nxt;
  end

endmodule

`default_nettype wire

//--- tb/ubfc_chk.sv
// Port checker for the baud and frame configuration block
`timescale 1ns/100ps
`default_nettype none
module ubfc_chk
  import ubfc_pkg::*;
(
  // Clock and reset
  input wire logic              sys_clk,
  input wire logic              rst,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  // Serial pins and tick
  input wire logic              txd,
  input wire logic              xck_out,
  input wire logic              xck_oe,
  input wire logic              baud_tick
);
  logic [DIV_W-1:0] div_r;
  logic [DIV_W-1:0] cnt_r;
  logic [15:0]      low_r;
  logic             sync_r;
  logic             pol_r;
  logic             dir_r;
  logic             ds_r;
  int               per;
  wire logic        wr_lo = reg_wr && reg_addr == ADDR_DIV_LOW;
  wire logic        wr_sh = reg_wr && reg_addr == ADDR_SHARED;
  wire logic        rd_sh = reg_rd && reg_addr == ADDR_SHARED;
  wire logic [3:0]  div_hi = div_r[11:8];
  wire logic [7:0]  div_lo = div_r[7:0];
  // Slave bits are paced from outside, so only internal clocking is timed
  always_comb per = (int'(div_r) + 1) * (sync_r ? 2 : (ds_r ? 8 : 16));
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      div_r <= RST_DIV;
      cnt_r <= '0;
      low_r <= '0;
      {sync_r, pol_r, dir_r, ds_r} <= '0;
    end
    else
    begin
      low_r <= txd ? 16'h0 : low_r + 16'h1;
      cnt_r <= (cnt_r == '0) ? div_r : cnt_r - 12'h1;
      if (wr_lo)
      begin
        div_r[7:0] <= reg_wdata;
        cnt_r      <= {div_hi, reg_wdata};
      end
      if (wr_sh && !reg_wdata[FC_SEL])
        div_r[11:8] <= reg_wdata[3:0];
      if (wr_sh && reg_wdata[FC_SEL])
        {sync_r, pol_r} <= {reg_wdata[FC_SYNC], reg_wdata[FC_POL]};
      if (reg_wr && reg_addr == ADDR_CTRL_B)
        {dir_r, ds_r} <= {reg_wdata[CB_CLKDIR], reg_wdata[CB_DSPEED]};
    end
  end
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_tick_count: assert property (baud_tick == (cnt_r == '0))
    else $error("Baud tick out of step");
  a_tick_reload: assert property (
    wr_lo && reg_wdata == 8'h03 && div_hi == '0 |=> !baud_tick [*3] ##1 baud_tick)
    else $error("Reload missed");
  a_rd_select: assert property (rd_sh |=> !reg_rdata[FC_SEL])
    else $error("Select bit read as one");
  a_rd_high: assert property (rd_sh |=> reg_rdata == {4'h0, $past(div_hi)})
    else $error("Divisor high read wrong");
  a_rd_low: assert property (
    reg_rd && reg_addr == ADDR_DIV_LOW |=> reg_rdata == $past(div_lo))
    else $error("Divisor low read wrong");
  a_clk_toggle: assert property (baud_tick |=> xck_out != $past(xck_out))
    else $error("Clock pin missed a tick");
  a_oe_mode: assert property (xck_oe == (sync_r && dir_r))
    else $error("Clock pin enable wrong");
  a_bit_len: assert property (
    $rose(txd) && !(sync_r && !dir_r) |-> low_r % per == 0)
    else $error("Bit period wrong");
  a_pol_launch: assert property ($changed(txd) && sync_r && dir_r |-> xck_out != pol_r)
    else $error("Data launched on wrong edge");
  c_reload: cover property (wr_lo ##1 baud_tick);
  c_sync_tx: cover property ($changed(txd) && sync_r && dir_r);
  c_rd_shared: cover property (rd_sh ##1 reg_rdata != '0);
endmodule

bind ubfc_top ubfc_chk u_chk (
  .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .txd(txd),
  .xck_out(xck_out), .xck_oe(xck_oe), .baud_tick(baud_tick)
);
`default_nettype wire

//--- tb/ubfc_far_end.sv
// Far-end serial transceiver model on the data and clock lines
`timescale 1ns/100ps
`default_nettype none
module ubfc_far_end (
  // Clock
  input  wire logic sys_clk,
  // Lines from the block
  input  wire logic txd,
  input  wire logic xck_out,
  // Lines to the block
  output var logic  rxd,
  output var logic  xck_in
);
  // Line marks high and the clock stands low outside frames
  initial
  begin
    rxd    = 1'b1;
    xck_in = 1'b0;
  end

  // Start, eight bits LSB first, stop; sck gives a launch-high clock per bit
  task automatic send(input logic [9:0] f, input int per, input bit sck);
    for (int i = 0; i < 10; i++)
    begin
      @(posedge sys_clk);
      rxd    <= f[i];
      xck_in <= sck;
      repeat (per / 2) @(posedge sys_clk);
      xck_in <= 1'b0;
      repeat (per / 2 - 1) @(posedge sys_clk);
    end
  endtask

  // Mid-bit sampling, or on the sampling clock edge in sync mode
  task automatic recv(input int n, input int per, input bit sync, input bit pol,
                      output logic [8:0] d);
    logic lx;
    d = '0;
    if (sync)
      for (int i = -1; i < n; i++)
      begin
        do
        begin
          lx = xck_out;
          @(negedge sys_clk);
        end
        while (lx == pol || xck_out != pol || (i < 0 && txd));
        if (i >= 0)
          d[i] = txd;
      end
    else
    begin
      @(negedge txd);
      repeat (per / 2) @(negedge sys_clk);
      for (int i = 0; i < n; i++)
      begin
        repeat (per) @(negedge sys_clk);
        d[i] = txd;
      end
    end
    // Return in the stop bit so a back-to-back start is not missed
    repeat (sync ? 8 : per) @(negedge sys_clk);
  endtask
endmodule
`default_nettype wire

//--- tb/usart_baud_and_frame_config_bench.sv
// Self-checking bench for the baud and frame configuration block
`timescale 1ns/100ps
`default_nettype none
module usart_baud_and_frame_config_bench
  import ubfc_pkg::*;
;
  logic              sys_clk = 1'b0;
  logic              rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic              rxd, txd, xck_in, xck_out, xck_oe, tx_fifo_ready, baud_tick;
  logic [8:0]        got;
  logic [2:0]        csz [6] = '{CSZ_5, CSZ_6, CSZ_7, CSZ_8, CSZ_9, 3'h4};
  int                nb [6] = '{5, 6, 7, 8, 9, 8};
  int                n;
  int                n_fail = 0;
  int                cmp_count = 0;
  int                cycles = 0;

  always #4 sys_clk = ~sys_clk;

  ubfc_top DUT (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rxd(rxd), .txd(txd),
    .xck_in(xck_in), .xck_out(xck_out), .xck_oe(xck_oe),
    .tx_fifo_ready(tx_fifo_ready), .baud_tick(baud_tick)
  );
  ubfc_far_end far (
    .sys_clk(sys_clk), .txd(txd), .xck_out(xck_out), .rxd(rxd), .xck_in(xck_in)
  );

  task automatic close_out();
    $display("Compares %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [8:0] g, input logic [8:0] e);
    cmp_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    chk({1'b0, reg_rdata}, {1'b0, e});
  endtask

  // Whole run needs well under ten thousand cycles
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      n_fail++;
      close_out();
    end
  end

  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    chk(xck_oe, 1'b0);
    rd(ADDR_DIV_LOW, 8'h00);
    rd(ADDR_SHARED, 8'h00);
    wr(ADDR_SHARED, 8'h0a);
    wr(ADDR_SHARED, 8'h86);
    rd(ADDR_SHARED, 8'h0a);
    rd(3'h7, 8'h00);
    wr(ADDR_SHARED, 8'h00);
    wr(ADDR_DIV_LOW, 8'h03);
    @(negedge sys_clk);
    while (!baud_tick)
      @(negedge sys_clk);
    n = 0;
    do
    begin
      @(negedge sys_clk);
      n++;
    end
    while (!baud_tick);
    chk(n[8:0], 9'h004);
    wr(ADDR_DIV_LOW, 8'h00);
    // Every data size code and reserved code 100, ninth bit preset to one
    for (int i = 0; i < 6; i++)
    begin
      wr(ADDR_SHARED, {5'h10, csz[i][1:0], 1'b0});
      wr(ADDR_CTRL_B, {7'h1c, csz[i][2]});
      fork
        far.recv(nb[i], 16, 1'b0, 1'b0, got);
        wr(ADDR_TX_DATA, 8'ha5);
      join
      chk(got, 9'h1a5 & ((9'h1 << nb[i]) - 9'h1));
    end
    wr(ADDR_SHARED, 8'h86);
    for (int i = 0; i < 2; i++)
    begin
      wr(ADDR_CTRL_B, {6'h06, i[0], 1'b0});
      far.send({1'b1, 8'h3c ^ i[7:0], 1'b0}, 16 >> i, 1'b0);
      rd(ADDR_STATUS, 8'h03);
      rd(ADDR_RX_DATA, 8'h3c ^ i[7:0]);
    end
    wr(ADDR_DIV_LOW, 8'h01);
    wr(ADDR_CTRL_B, 8'h1c);
    rd(ADDR_CTRL_B, 8'h1c);
    for (int p = 0; p < 2; p++)
    begin
      wr(ADDR_SHARED, {7'h63, p[0]});
      @(negedge sys_clk);
      chk(xck_oe, 1'b1);
      fork
        far.recv(8, 0, 1'b1, p[0], got);
        wr(ADDR_TX_DATA, 8'h96 ^ p[7:0]);
      join
      chk(got, 9'h096 ^ p[8:0]);
    end
    wr(ADDR_CTRL_B, 8'h18);
    wr(ADDR_SHARED, 8'hc6);
    @(negedge sys_clk);
    chk(xck_oe, 1'b0);
    far.send({1'b1, 8'h5a, 1'b0}, 16, 1'b1);
    rd(ADDR_RX_DATA, 8'h5a);
    wr(ADDR_SHARED, 8'h86);
    wr(ADDR_DIV_LOW, 8'h00);
    // Transmit held off so the FIFO fills; the extra word must be dropped
    wr(ADDR_CTRL_B, 8'h10);
    for (int k = 0; k < 17; k++)
    begin
      @(negedge sys_clk);
      chk(tx_fifo_ready, k < 16);
      wr(ADDR_TX_DATA, k[7:0]);
    end
    fork
      wr(ADDR_CTRL_B, 8'h18);
      for (int k = 0; k < 16; k++)
      begin
        far.recv(8, 16, 1'b0, 1'b0, got);
        chk(got, k[8:0]);
      end
    join
    close_out();
  end
endmodule
`default_nettype wire
